// ### dfic_pkg.sv
// shared constants for the drive fault and input configuration block
package dfic_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int PIN_W = 16;
    localparam int CLK_MHZ = 250;
    // parameter offsets
    localparam logic [7:0] INPUT_PULLUP_MODE_CONFIG_OFS = 8'hA5;
    localparam logic [7:0] DEBOUNCED_INPUT_LEVELS_OFS = 8'hA6;
    localparam logic [7:0] FAULT_MASK_UPPER_OFS = 8'hA7;
    // fault mask field positions
    localparam int MASK_CMD_LOST_BIT = 12;
    localparam int MASK_HW_INIT_BIT = 13;
    localparam int MASK_SAFETY_BIT = 14;
    localparam int MASK_CURR_BIT = 15;
    localparam int MASK_WIRING_BIT = 16;
    localparam logic [31:0] MASK_WR_BITS = 32'h0001_D000;
    localparam logic [31:0] FAULT_MASK_RST = 32'h0000_0000;
    // input configuration fields
    localparam int CFG_DIFF_BIT = 8;
    localparam logic [15:0] INPUT_CFG_RST = 16'h0000;
    localparam logic [15:0] LEVELS_RST = 16'h0000;
    // debounce sample period
    localparam int SAMPLE_TIME_NS = 1000;
    localparam int SAMPLE_DIV = SAMPLE_TIME_NS * CLK_MHZ / 1000;
    localparam int DEB_SAMPLES_DEF = 8;
endpackage

// ### dfic_deb_if.sv
// raw pins in, debounced levels out, plus sample tick
`timescale 1ns/1ps
interface dfic_deb_if #(parameter int W = 16);
    logic [W-1:0] raw;
    logic tick;
    logic [W-1:0] levels;
    modport ctl (output raw, output tick, input levels);
    modport deb (input raw, input tick, output levels);
endinterface

// ### dfic_debounce.sv
// per-pin debounce filter on a sample tick
`timescale 1ns/1ps
module dfic_debounce #(
    parameter int W = 16,
    parameter int SAMPLES = dfic_pkg::DEB_SAMPLES_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins
    dfic_deb_if.deb dbi
);
    import dfic_pkg::*;
    localparam int CW = $clog2(SAMPLES + 1);
    localparam logic [CW-1:0] LAST = CW'(SAMPLES - 1);

    logic [W-1:0] lvl_r, lvl_nxt;
    logic [CW-1:0] cnt_r [W], cnt_nxt [W];

    // a level flips only after SAMPLES differing samples in a row
    always_comb begin
        lvl_nxt = lvl_r;
        for (int i = 0; i < W; i++) begin
            cnt_nxt[i] = cnt_r[i];
            if (dbi.raw[i] == lvl_r[i]) begin
                cnt_nxt[i] = '0;
            end else if (dbi.tick) begin
                if (cnt_r[i] == LAST) begin
                    lvl_nxt[i] = dbi.raw[i];
                    cnt_nxt[i] = '0;
                end else begin
                    cnt_nxt[i] = cnt_r[i] + CW'(1);
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lvl_r <= W'(LEVELS_RST);
            for (int i = 0; i < W; i++) begin
                cnt_r[i] <= '0;
            end
        end else begin
            lvl_r <= lvl_nxt;
            for (int i = 0; i < W; i++) begin
                cnt_r[i] <= cnt_nxt[i];
            end
        end
    end

    assign dbi.levels = lvl_r;

    a_deb_on_tick: assert property (@(posedge clk) disable iff (rst)
        $changed(lvl_r) |-> $past(dbi.tick))
        else $error("level changed without a sample tick");
    a_deb_to_raw: assert property (@(posedge clk) disable iff (rst)
        $changed(lvl_r[0]) |-> lvl_r[0] == $past(dbi.raw[0]))
        else $error("level moved away from raw input");
    c_deb_flip: cover property (@(posedge clk) disable iff (rst)
        $changed(lvl_r[0]));
endmodule

// ### dfic_top.sv
// fault mask upper bits, input configuration and input level registers
`timescale 1ns/1ps
module dfic_top #(
    parameter int NUM_PULLUPS = 8,
    parameter int DEB_SAMPLES = dfic_pkg::DEB_SAMPLES_DEF,
    parameter int SAMPLE_DIV = dfic_pkg::SAMPLE_DIV
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // parameter access
    input wire logic [dfic_pkg::ADDR_W-1:0] PAR_ADDR,
    input wire logic PAR_WR,
    input wire logic PAR_RD,
    input wire logic [dfic_pkg::DATA_W-1:0] PAR_WDATA,
    output logic [dfic_pkg::DATA_W-1:0] PAR_RDATA,
    output logic PAR_ACK,
    // fault events
    input wire logic CMD_LOST,
    input wire logic HW_INIT_FAIL,
    input wire logic SAFETY_CHK_FAIL,
    input wire logic CURR_UNCTRL,
    input wire logic WIRING_OPEN,
    input wire logic FAULT_CLEAR,
    output logic FAULT_LATCHED,
    output logic OUTPUT_DISABLE,
    // input pins
    input wire logic [dfic_pkg::PIN_W-1:0] INPUT_PINS,
    output logic [NUM_PULLUPS-1:0] PULLUP_EN,
    output logic DIFF_MODE
);
    import dfic_pkg::*;
    localparam int DW = $clog2(SAMPLE_DIV + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(SAMPLE_DIV - 1);

    // writable bits of the configuration register
    function automatic logic [15:0] cfg_wr_bits(input int n);
        logic [15:0] m;
        m = '0;
        for (int i = 0; i < n; i++) begin
            m[i] = 1'b1;
        end
        m[CFG_DIFF_BIT] = 1'b1;
        return m;
    endfunction
    localparam logic [15:0] CFG_WR = cfg_wr_bits(NUM_PULLUPS);

    logic [15:0] cfg_r, cfg_nxt;
    logic [31:0] mask_r, mask_nxt;
    logic fault_r, fault_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    logic [DW-1:0] div_r, div_nxt;
    logic [31:0] mask_view;
    logic ev_latch;
    logic wr_cfg, wr_mask;

    dfic_deb_if #(.W(PIN_W)) dbi ();

    dfic_debounce #(.W(PIN_W), .SAMPLES(DEB_SAMPLES)) u_deb (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .dbi(dbi.deb)
    );

    assign dbi.raw = INPUT_PINS;
    assign dbi.tick = (div_r == DIV_LAST);

    assign wr_cfg = PAR_WR && PAR_ADDR == INPUT_PULLUP_MODE_CONFIG_OFS;
    assign wr_mask = PAR_WR && PAR_ADDR == FAULT_MASK_UPPER_OFS;

    // bit 13 is a live status bit, never stored
    always_comb begin
        mask_view = mask_r;
        mask_view[MASK_HW_INIT_BIT] = HW_INIT_FAIL;
    end

    assign ev_latch =
        (CMD_LOST && mask_r[MASK_CMD_LOST_BIT]) ||
        HW_INIT_FAIL ||
        (SAFETY_CHK_FAIL && mask_r[MASK_SAFETY_BIT]) ||
        (CURR_UNCTRL && mask_r[MASK_CURR_BIT]) ||
        (WIRING_OPEN && mask_r[MASK_WIRING_BIT]);

    always_comb begin
        div_nxt = dbi.tick ? '0 : div_r + DW'(1);
        cfg_nxt = cfg_r;
        mask_nxt = mask_r;
        if (wr_cfg) begin
            cfg_nxt = PAR_WDATA[15:0] & CFG_WR;
        end
        if (wr_mask) begin
            mask_nxt = PAR_WDATA & MASK_WR_BITS;
        end
        // a new event wins over a clear in the same cycle
        if (ev_latch) begin
            fault_nxt = 1'b1;
        end else if (FAULT_CLEAR) begin
            fault_nxt = 1'b0;
        end else begin
            fault_nxt = fault_r;
        end
        ack_nxt = PAR_WR || PAR_RD;
        rdata_nxt = rdata_r;
        if (PAR_RD) begin
            case (PAR_ADDR)
                INPUT_PULLUP_MODE_CONFIG_OFS: rdata_nxt = {16'h0000, cfg_r};
                DEBOUNCED_INPUT_LEVELS_OFS:
                    rdata_nxt = {16'h0000, dbi.levels};
                FAULT_MASK_UPPER_OFS: rdata_nxt = mask_view;
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_r <= '0;
            cfg_r <= INPUT_CFG_RST;
            mask_r <= FAULT_MASK_RST;
            fault_r <= 1'b0;
            rdata_r <= '0;
            ack_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            cfg_r <= cfg_nxt;
            mask_r <= mask_nxt;
            fault_r <= fault_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign PAR_RDATA = rdata_r;
    assign PAR_ACK = ack_r;
    assign FAULT_LATCHED = fault_r;
    assign OUTPUT_DISABLE = fault_r;
    assign PULLUP_EN = cfg_r[NUM_PULLUPS-1:0];
    assign DIFF_MODE = cfg_r[CFG_DIFF_BIT];

    a_cmd_lost_latch: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        CMD_LOST && mask_r[MASK_CMD_LOST_BIT] |=> OUTPUT_DISABLE)
        else $error("command loss did not disable outputs");
    a_init_bit_ro: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        PAR_RD && PAR_ADDR == FAULT_MASK_UPPER_OFS
        |=> PAR_RDATA[MASK_HW_INIT_BIT] == $past(HW_INIT_FAIL))
        else $error("mask bit 13 does not show init status");
    a_safety_latch: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        SAFETY_CHK_FAIL && mask_r[MASK_SAFETY_BIT] && FAULT_CLEAR
        |=> FAULT_LATCHED)
        else $error("safety failure lost against clear");
    a_current_latch: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        CURR_UNCTRL && mask_r[MASK_CURR_BIT] |=> FAULT_LATCHED)
        else $error("current fault not latched");
    a_wiring_latch: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        WIRING_OPEN && mask_r[MASK_WIRING_BIT] |=> FAULT_LATCHED)
        else $error("open wiring not latched");
    a_masked_quiet: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !FAULT_LATCHED && !HW_INIT_FAIL && mask_r[16:12] == 5'h00
        |=> !FAULT_LATCHED)
        else $error("fault latched with every event masked");
    a_pullup_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        wr_cfg |=> PULLUP_EN == $past(PAR_WDATA[NUM_PULLUPS-1:0]))
        else $error("pull-up enables do not follow write");
    a_diff_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        wr_cfg |=> DIFF_MODE == $past(PAR_WDATA[CFG_DIFF_BIT]))
        else $error("input mode does not follow write");
    a_levels_read: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        PAR_RD && PAR_ADDR == DEBOUNCED_INPUT_LEVELS_OFS
        |=> PAR_RDATA == {16'h0000, $past(dbi.levels)} && PAR_ACK)
        else $error("input level read returned wrong data");
    a_levels_ro: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        PAR_WR && PAR_ADDR == DEBOUNCED_INPUT_LEVELS_OFS
        |=> $stable(cfg_r) && $stable(mask_r))
        else $error("write to input levels changed a register");
    // latch, mask and configuration bookkeeping
    a_init_latch: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        HW_INIT_FAIL |=> FAULT_LATCHED)
        else $error("init failure did not latch a fault");
    a_clear_drop: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        FAULT_CLEAR && !ev_latch |=> !FAULT_LATCHED)
        else $error("fault stayed latched after a clear");
    a_hold_latched: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        FAULT_LATCHED && !FAULT_CLEAR |=> FAULT_LATCHED)
        else $error("latched fault dropped without a clear");
    a_mask_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        wr_mask
        |=> mask_r == ($past(PAR_WDATA) & MASK_WR_BITS))
        else $error("mask register does not follow write");
    a_cfg_unused: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        PAR_RD && PAR_ADDR == INPUT_PULLUP_MODE_CONFIG_OFS
        |=> (PAR_RDATA & ~{16'h0000, CFG_WR}) == '0)
        else $error("unused configuration bits read nonzero");
    a_cfg_stable: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !wr_cfg |=> $stable(cfg_r))
        else $error("configuration changed without a write");
    a_mask_stable: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !wr_mask |=> $stable(mask_r))
        else $error("mask changed without a write");

    c_fault_rise: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
        $rose(FAULT_LATCHED));
    c_fault_cleared: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
        $fell(FAULT_LATCHED));
    c_diff_on: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
        $rose(DIFF_MODE));
    c_levels_read: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
        PAR_RD && PAR_ADDR == DEBOUNCED_INPUT_LEVELS_OFS);
endmodule

// ### dfic_host.sv
// host model issuing parameter reads and writes
`timescale 1ns/1ps
module dfic_host (
    // parameter bus
    input wire logic clk,
    output logic [7:0] addr,
    output logic wr,
    output logic rd,
    output logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic ack
);
    initial begin
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 32'h0000_0000;
    end
    // one strobe cycle, answer taken at the ack edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge clk);
        // strobe is a one-cycle pulse; address and data stay to the ack
        wr = 1'b0;
        rd = 1'b0;
        @(posedge clk);
        q = (ack === 1'b1) ? rdata : 32'hDEAD_BEEF;
        @(negedge clk);
        // released lines must not keep the last value
        addr = ~a;
        wdata = ~d;
    endtask
endmodule

// ### drive_fault_input_config_bench.sv
// self-checking bench for fault mask, input config and input levels
`timescale 1ns/1ps
module drive_fault_input_config_bench;
    import dfic_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] ev = 5'h00;
    logic clr = 1'b0;
    logic [15:0] pins = 16'h0000;
    logic [7:0] addr;
    logic wr, rd, ack, flt, dis, diff, e;
    logic [31:0] wdata, rdata, q, d;
    logic [7:0] pu;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;

    initial forever #2 clk = ~clk;

    dfic_host u_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd),
        .wdata(wdata), .rdata(rdata), .ack(ack));
    dfic_top #(.NUM_PULLUPS(8), .DEB_SAMPLES(2), .SAMPLE_DIV(4)) u_dut (
        .REF_CLK(clk), .SYS_RST(rst), .PAR_ADDR(addr), .PAR_WR(wr),
        .PAR_RD(rd), .PAR_WDATA(wdata), .PAR_RDATA(rdata), .PAR_ACK(ack),
        .CMD_LOST(ev[0]), .HW_INIT_FAIL(ev[1]), .SAFETY_CHK_FAIL(ev[2]),
        .CURR_UNCTRL(ev[3]), .WIRING_OPEN(ev[4]), .FAULT_CLEAR(clr),
        .FAULT_LATCHED(flt), .OUTPUT_DISABLE(dis), .INPUT_PINS(pins),
        .PULLUP_EN(pu), .DIFF_MODE(diff));

    function automatic logic [31:0] exp_cfg(logic [31:0] v);
        return {16'h0000, v[15:0] & 16'h01FF};
    endfunction
    function automatic logic [31:0] exp_mask(logic [31:0] v, logic hw);
        return (v & MASK_WR_BITS) | (32'(hw) << MASK_HW_INIT_BIT);
    endfunction

    task automatic chk(logic [31:0] s, logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            errors++;
            $display("Error %0t: saw %h expected %h", $time, s, x);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'hE1AF176A));
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk(32'({pu, diff, flt, dis}), 32'h0000_0000);
        // three mapped registers then one unmapped place
        for (int i = 0; i < 4; i++) begin
            u_host.xfer(1'b0, 8'hA5 + 8'(i), 32'h0, q);
            chk(q, 32'h0000_0000);
        end
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 32'hFFFF_FFFF : $urandom();
            u_host.xfer(1'b1, INPUT_PULLUP_MODE_CONFIG_OFS, d, q);
            chk(32'({pu, diff}), 32'({d[7:0], d[8]}));
            u_host.xfer(1'b0, INPUT_PULLUP_MODE_CONFIG_OFS, 32'h0, q);
            chk(q, exp_cfg(d));
        end
        // each event with its mask bit set, then with all bits clear
        for (int i = 0; i < 10; i++) begin
            d = (i < 5) ? (32'h1 << (12 + i)) : 32'h0;
            u_host.xfer(1'b1, FAULT_MASK_UPPER_OFS, d, q);
            @(negedge clk);
            ev[i % 5] = 1'b1;
            e = (i < 5) || (i % 5 == 1);
            @(negedge clk);
            ev = 5'h00;
            chk(32'({flt, dis}), 32'({e, e}));
            clr = 1'b1;
            @(negedge clk);
            clr = 1'b0;
            @(negedge clk);
            chk(32'({flt, dis}), 32'h0);
        end
        // event and clear in one cycle: the event wins
        u_host.xfer(1'b1, FAULT_MASK_UPPER_OFS, 32'h0000_4000, q);
        @(negedge clk);
        ev[2] = 1'b1;
        clr = 1'b1;
        @(negedge clk);
        ev = 5'h00;
        chk(32'(flt), 32'h1);
        @(negedge clk);
        clr = 1'b0;
        chk(32'(flt), 32'h0);
        u_host.xfer(1'b1, FAULT_MASK_UPPER_OFS, 32'hFFFF_FFFF, q);
        @(negedge clk);
        ev[1] = 1'b1;
        u_host.xfer(1'b0, FAULT_MASK_UPPER_OFS, 32'h0, q);
        chk(q, exp_mask(32'hFFFF_FFFF, 1'b1));
        ev = 5'h00;
        chk(32'(flt), 32'h1);
        u_host.xfer(1'b0, FAULT_MASK_UPPER_OFS, 32'h0, q);
        chk(q, exp_mask(32'hFFFF_FFFF, 1'b0));
        for (int k = 0; k < 5; k++) begin
            @(negedge clk);
            pins = (k == 0) ? 16'h0001 : 16'($urandom());
            repeat (40) @(negedge clk);
            u_host.xfer(1'b0, DEBOUNCED_INPUT_LEVELS_OFS, 32'h0, q);
            chk(q, {16'h0000, pins});
            // one-cycle glitch must not pass the filter
            @(negedge clk);
            d = {16'h0000, pins};
            pins = ~pins;
            @(negedge clk);
            pins = d[15:0];
            u_host.xfer(1'b1, DEBOUNCED_INPUT_LEVELS_OFS, ~d, q);
            repeat (20) @(negedge clk);
            u_host.xfer(1'b0, DEBOUNCED_INPUT_LEVELS_OFS, 32'h0, q);
            chk(q, d);
        end
        wrap_up();
    end
endmodule
